// ==== core/mpo_pkg.sv ====
// constants and types for the macrocell preload / observe test logic
package mpo_pkg;
	localparam int MPO_CELLS = 16;
	localparam int MPO_CLK_PERIOD_NS = 5;
	// power-up reset time, microseconds
	localparam int MPO_PWRUP_US = 10;
	// power-up reset duration in cycles (longest time, rounds down)
	localparam int MPO_PWRUP_CYCLES = (MPO_PWRUP_US * 1000) / MPO_CLK_PERIOD_NS;
	// reset value of every macrocell register
	localparam logic MPO_REG_RESET = 1'b0;
	// mode encodings, one-hot
	typedef enum logic [2:0] {
		MPO_NORMAL = 3'h1,
		MPO_PRELOAD = 3'h2,
		MPO_OBSERVE = 3'h4
	} mpo_mode_t;
endpackage

// ==== core/mpo_cell_if.sv ====
// bundle between the mode control and the macrocell bank
interface mpo_cell_if #(parameter int CELLS = 16);
	import mpo_pkg::*;
	mpo_mode_t mode;
	logic clk_edge;
	logic [CELLS-1:0] q;
	modport ctrl (output mode, output clk_edge, input q);
	modport bank (input mode, input clk_edge, output q);
endinterface

// ==== core/mpo_cell_bank.sv ====
// bank of macrocell registers with preload load path
module mpo_cell_bank #(
	parameter int CELLS = 16
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [CELLS-1:0] d_in,
	input wire logic [CELLS-1:0] pin_in,
	mpo_cell_if.bank cif
);
	import mpo_pkg::*;
	genvar i;
	generate
		for (i = 0; i < CELLS; i++) begin : g_cell
			always_ff @(posedge clk_in) begin
				if (!rst_n_in) begin
					cif.q[i] <= MPO_REG_RESET;
				end else if (cif.clk_edge) begin
					if (cif.mode == MPO_PRELOAD) begin
						cif.q[i] <= pin_in[i];
					end else if (cif.mode == MPO_NORMAL) begin
						cif.q[i] <= d_in[i];
					end
				end
			end
		end
	endgenerate
endmodule

// ==== core/mpo_test_port.sv ====
// top: mode decode, pin drive and power-up reset for the macrocell test port
module mpo_test_port #(
	parameter int CELLS = mpo_pkg::MPO_CELLS,
	parameter int PWRUP_CYCLES = mpo_pkg::MPO_PWRUP_CYCLES
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic preload_term_in,
	input wire logic observe_term_in,
	input wire logic dev_clk_in,
	input wire logic [CELLS-1:0] d_in,
	input wire logic [CELLS-1:0] polarity_in,
	input wire logic [CELLS-1:0] oe_in,
	input wire logic [CELLS-1:0] pin_in,
	output logic [CELLS-1:0] pin_out,
	output logic [CELLS-1:0] pin_oe_out,
	output mpo_pkg::mpo_mode_t mode_out,
	output logic reset_busy_out
);
	import mpo_pkg::*;
	mpo_cell_if #(.CELLS(CELLS)) cif ();

	// mode control
	mpo_mode_t mode;
	mpo_mode_t next_mode;
	logic preload_req;
	logic observe_req;

	// power-up window and device clock edge
	logic [31:0] pwr_cnt;
	logic [31:0] next_pwr_cnt;
	logic dev_clk_q;
	logic dev_clk_rise;

	// pin drive
	logic [CELLS-1:0] next_pin;
	logic [CELLS-1:0] next_oe;

	// power-up window: clock edges and test modes are ignored until it ends
	// a 32-bit count covers any window length a parameter can ask for
	always_comb begin
		next_pwr_cnt = pwr_cnt;
		if (pwr_cnt < 32'(PWRUP_CYCLES)) begin
			next_pwr_cnt = pwr_cnt + 32'h1;
		end
	end

	// the counter saturates, so a long run never reopens the window
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			pwr_cnt <= 32'h0;
		end else begin
			pwr_cnt <= next_pwr_cnt;
		end
	end

	always_comb begin
		reset_busy_out = (pwr_cnt < 32'(PWRUP_CYCLES));
	end

	// terms count only once the window has closed
	always_comb begin
		preload_req = preload_term_in & ~reset_busy_out;
		observe_req = observe_term_in & ~reset_busy_out;
	end

	// preload takes priority: observe would drive pins the tester is driving
	always_comb begin
		next_mode = MPO_NORMAL;
		case (mode)
			MPO_NORMAL: begin
				if (preload_req) begin
					next_mode = MPO_PRELOAD;
				end else if (observe_req) begin
					next_mode = MPO_OBSERVE;
				end
			end
			// observe may follow preload directly, without a normal cycle
			MPO_PRELOAD: begin
				if (preload_req) begin
					next_mode = MPO_PRELOAD;
				end else if (observe_req) begin
					next_mode = MPO_OBSERVE;
				end
			end
			// a preload term arriving during observe takes over at once
			MPO_OBSERVE: begin
				if (preload_req) begin
					next_mode = MPO_PRELOAD;
				end else if (observe_req) begin
					next_mode = MPO_OBSERVE;
				end
			end
			default: begin
				next_mode = MPO_NORMAL;
			end
		endcase
	end

	// the busy branch repeats the term gating but keeps the window explicit
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			mode <= MPO_NORMAL;
		end else if (reset_busy_out) begin
			mode <= MPO_NORMAL;
		end else begin
			mode <= next_mode;
		end
	end

	// rising edge of the device clock pin; the pin is synchronous to clk_in
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			dev_clk_q <= 1'b0;
		end else begin
			dev_clk_q <= dev_clk_in;
		end
	end

	// the clock is held low after reset, so a cleared history gives no false edge
	always_comb begin
		dev_clk_rise = dev_clk_in & ~dev_clk_q;
	end

	// pin loopback in preload means a pin-based term can disturb itself
	// limitation: nothing here can tell a pin-built term from a dedicated one
	always_comb begin
		cif.mode = mode;
		cif.clk_edge = dev_clk_rise & ~reset_busy_out;
	end

	// the bank keeps Q through observe; only preload and normal edges load it
	mpo_cell_bank #(.CELLS(CELLS)) u_bank (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.d_in(d_in),
		.pin_in(pin_in),
		.cif(cif)
	);

	// per-cell pin drive; observe shows raw Q so the tester reads the register itself
	genvar c;
	generate
		for (c = 0; c < CELLS; c++) begin : g_pin
			// value path
			always_comb begin
				next_pin[c] = cif.q[c] ^ polarity_in[c];
				case (mode)
					MPO_OBSERVE: begin
						next_pin[c] = cif.q[c];
					end
					MPO_PRELOAD: begin
						next_pin[c] = cif.q[c] ^ polarity_in[c];
					end
					MPO_NORMAL: begin
						next_pin[c] = cif.q[c] ^ polarity_in[c];
					end
					default: begin
						next_pin[c] = cif.q[c] ^ polarity_in[c];
					end
				endcase
			end

			// enable path
			always_comb begin
				next_oe[c] = 1'b0;
				case (mode)
					MPO_OBSERVE: begin
						next_oe[c] = 1'b1;
					end
					// released so the tester can drive the load value
					MPO_PRELOAD: begin
						next_oe[c] = 1'b0;
					end
					MPO_NORMAL: begin
						next_oe[c] = oe_in[c];
					end
					default: begin
						next_oe[c] = 1'b0;
					end
				endcase
			end

			// reset drives low; polarity applies from the first normal cycle
			always_ff @(posedge clk_in) begin
				if (!rst_n_in) begin
					pin_out[c] <= 1'b0;
				end else begin
					pin_out[c] <= next_pin[c];
				end
			end

			// outputs stay off through reset so nothing fights the tester
			always_ff @(posedge clk_in) begin
				if (!rst_n_in) begin
					pin_oe_out[c] <= 1'b0;
				end else begin
					pin_oe_out[c] <= next_oe[c];
				end
			end
		end
	endgenerate

	// mode is exported so a tester can see which test mode is live
	always_comb begin
		mode_out = mode;
	end
endmodule

// ==== sim/mpo_test_port_properties.sv ====
// assertions on the macrocell test port pins
module mpo_test_port_checker #(parameter int CELLS = 16) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic preload_term_in,
	input wire logic observe_term_in,
	input wire logic dev_clk_in,
	input wire logic [CELLS-1:0] polarity_in,
	input wire logic [CELLS-1:0] oe_in,
	input wire logic [CELLS-1:0] pin_in,
	input wire logic [CELLS-1:0] pin_out,
	input wire logic [CELLS-1:0] pin_oe_out,
	input wire mpo_pkg::mpo_mode_t mode_out,
	input wire logic reset_busy_out
);
	timeunit 1ns / 1ps;
	import mpo_pkg::*;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	sequence pulse_s;
		mode_out == MPO_PRELOAD && dev_clk_in && !$past(dev_clk_in);
	endsequence
	pre_on_a: assert property (!reset_busy_out && preload_term_in |=> mode_out == MPO_PRELOAD)
		else $error("preload");
	obs_on_a: assert property (observe_term_in && !preload_term_in && !reset_busy_out
		|=> mode_out == MPO_OBSERVE) else $error("observe");
	busy_hold_a: assert property (reset_busy_out |=> mode_out == MPO_NORMAL)
		else $error("busy");
	obs_oe_a: assert property (mode_out == MPO_OBSERVE |=> pin_oe_out == '1)
		else $error("oe");
	pre_oe_a: assert property (mode_out == MPO_PRELOAD |=> pin_oe_out == '0)
		else $error("preload enable");
	load_pin_a: assert property (pulse_s |-> ##2
		pin_out == ($past(pin_in, 2) ^ $past(polarity_in, 2))) else $error("load");
	obs_hold_a: assert property ((mode_out == MPO_OBSERVE) [*3] |=> $stable(pin_out))
		else $error("hold");
	norm_oe_a: assert property (mode_out == MPO_NORMAL && !reset_busy_out
		|=> pin_oe_out == $past(oe_in)) else $error("enable");
	reset_pol_a: assert property ($fell(reset_busy_out) |=> pin_out == $past(polarity_in))
		else $error("polarity");
endmodule
bind mpo_test_port mpo_test_port_checker #(.CELLS(CELLS)) chk_u (
	.clk_in(clk_in),
	.rst_n_in(rst_n_in),
	.preload_term_in(preload_term_in),
	.observe_term_in(observe_term_in),
	.dev_clk_in(dev_clk_in),
	.polarity_in(polarity_in),
	.oe_in(oe_in),
	.pin_in(pin_in),
	.pin_out(pin_out),
	.pin_oe_out(pin_oe_out),
	.mode_out(mode_out),
	.reset_busy_out(reset_busy_out)
);

// ==== sim/mpo_tester.sv ====
// tester model on the macrocell i/o pins
module mpo_tester (
	input wire logic clk_in,
	input wire logic drive_in,
	input wire logic [15:0] value_in,
	input wire logic [15:0] pin_out,
	input wire logic [15:0] pin_oe_out,
	output logic [15:0] pin_in
);
	timeunit 1ns / 1ps;
	// released pins show value_in while drive_in is high, else the inverse of the device value, so a stale level never passes
	always_ff @(posedge clk_in) begin
		pin_in <= pin_oe_out & pin_out | ~pin_oe_out & (drive_in ? value_in : ~pin_out);
	end
endmodule

// ==== sim/test_macrocell_preload_observe_test.sv ====
// self-checking bench for the macrocell test port
module test_macrocell_preload_observe_test;
	timeunit 1ns / 1ps;
	import mpo_pkg::*;
	logic clk_in = 1'h0, rst_n_in = 1'h0, dev_clk_in = 1'h0, reset_busy_out;
	logic preload_term_in = 1'h0, observe_term_in = 1'h0, drive_pins = 1'h0;
	logic [15:0] d_in = 16'h0000, polarity_in = 16'h00ff, oe_in = 16'h0f0f, value_in = 16'h0000;
	logic [15:0] pin_in, pin_out, pin_oe_out;
	mpo_mode_t mode_out;
	int errors = 0, samples_checked = 0;
	always #2.5 clk_in = ~clk_in;
	mpo_test_port #(.PWRUP_CYCLES(8)) DUT (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .preload_term_in(preload_term_in),
		.observe_term_in(observe_term_in), .dev_clk_in(dev_clk_in), .d_in(d_in),
		.polarity_in(polarity_in), .oe_in(oe_in), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe_out(pin_oe_out), .mode_out(mode_out), .reset_busy_out(reset_busy_out));
	mpo_tester TM (
		.clk_in(clk_in), .drive_in(drive_pins), .value_in(value_in),
		.pin_out(pin_out), .pin_oe_out(pin_oe_out), .pin_in(pin_in));
	task chk(input logic [15:0] got, exp);
		samples_checked++;
		errors += int'(got !== exp);
		if (got !== exp)
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
	endtask
	task chk_mode(input mpo_mode_t got, exp);
		samples_checked++;
		errors += int'(got !== exp);
		if (got !== exp)
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
	endtask
	task chk_flag(input logic got, exp);
		samples_checked++;
		errors += int'(got !== exp);
		if (got !== exp)
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
	endtask
	task step(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task results;
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// reset held six cycles, then reset_busy_out must be high five cycles after release and low five cycles later
	task t_power_up;
		step(6);
		chk(pin_out, 16'h0000);
		chk(pin_oe_out, 16'h0000);
		chk_mode(mode_out, MPO_NORMAL);
		rst_n_in = 1'h1;
		step(5);
		chk_flag(reset_busy_out, 1'h1);
		step(5);
		chk_flag(reset_busy_out, 1'h0);
		chk(pin_out, polarity_in);
		chk(pin_oe_out, oe_in);
	endtask
	// both terms high: preload must win, then observe once preload drops
	task t_preload_observe(input logic [15:0] v);
		value_in = v;
		drive_pins = 1'h1;
		preload_term_in = 1'h1;
		observe_term_in = 1'h1;
		step(4);
		chk_mode(mode_out, MPO_PRELOAD);
		chk(pin_oe_out, 16'h0000);
		dev_clk_in = 1'h1;
		step(1);
		dev_clk_in = 1'h0;
		step(2);
		chk(pin_out, v ^ polarity_in);
		drive_pins = 1'h0;
		step(1);
		preload_term_in = 1'h0;
		step(3);
		chk_mode(mode_out, MPO_OBSERVE);
		chk(pin_out, v);
		chk(pin_oe_out, 16'hffff);
		// a pulse in observe must not load the zero on d_in
		dev_clk_in = 1'h1;
		step(1);
		dev_clk_in = 1'h0;
		observe_term_in = 1'h0;
		step(3);
		chk(pin_out, v ^ polarity_in);
		chk_mode(mode_out, MPO_NORMAL);
		chk(pin_oe_out, oe_in);
	endtask
	// mid-run reset clears the preloaded registers; a pulse in the window is ignored
	task t_reset_mid(input logic [15:0] d);
		rst_n_in = 1'h0;
		step(2);
		chk(pin_out, 16'h0000);
		chk(pin_oe_out, 16'h0000);
		chk_mode(mode_out, MPO_NORMAL);
		chk_flag(reset_busy_out, 1'h1);
		rst_n_in = 1'h1;
		d_in = d;
		dev_clk_in = 1'h1;
		step(1);
		dev_clk_in = 1'h0;
		step(9);
		chk(pin_out, polarity_in);
		dev_clk_in = 1'h1;
		step(1);
		dev_clk_in = 1'h0;
		step(2);
		chk(pin_out, d ^ polarity_in);
	endtask
	initial begin
		t_power_up;
		t_preload_observe(16'ha5c3);
		t_reset_mid(16'h1234);
		results;
	end
	// the scenarios need about 50 cycles; the ceiling leaves wide margin
	initial begin
		repeat (400) @(posedge clk_in);
		errors++;
		results;
	end
endmodule
